// >>> common/tmr_pkg.sv
package tmr_pkg;

    localparam int DATA_W = 8;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 4;

    // Byte addresses of the register words
    localparam logic [ADDR_W-1:0] MODE_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] PERIOD_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] DUTY_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hC;

    localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PERIOD_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DUTY_RESET = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;

    // Count clocks a duty write must age before it may be committed
    localparam logic [1:0] DUTY_SETTLE = 2'h3;

    // Operating modes held in the mode field
    localparam logic [1:0] MODE_INTERVAL = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;

    // Prescaler exponents per count clock select code
    localparam logic [3:0] EXP_SEL0 = 4'h0;
    localparam logic [3:0] EXP_SEL1 = 4'h2;
    localparam logic [3:0] EXP_SEL2 = 4'h4;
    localparam logic [3:0] EXP_SEL3 = 4'h6;
    localparam logic [3:0] EXP_SEL4 = 4'hC;
    localparam logic [3:0] EXP_SEL5 = 4'h6;
    localparam logic [3:0] EXP_SEL6 = 4'hF;
    localparam logic [3:0] EXP_SEL7 = 4'h0;
    localparam int PRESCALE_W = 15;

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic count_run_enable;
        logic [2:0] count_clock_select;
        logic [1:0] op_mode;
        logic idle_level_select;
        logic pin_drive_enable;
    } timer_mode_reg_t;

    // Status word layout, low byte the live counter
    typedef struct packed {
        logic duty_pending;
        logic duty_selected;
        logic out_phase;
        logic pin_level;
        logic [DATA_W-1:0] count;
    } timer_status_t;

endpackage

// >>> rtl/count_clock_prescaler.sv
`timescale 1ns/10ps
module count_clock_prescaler #(
    parameter logic [3:0] EXP_SLOW = tmr_pkg::EXP_SEL6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] count_clock_select,
    output logic count_tick
);
    logic [tmr_pkg::PRESCALE_W-1:0] div;
    logic [tmr_pkg::PRESCALE_W-1:0] mask;
    logic [3:0] exp_sel;

    // Free running so a start waits at most one count clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
        end else if (clk_en) begin
            div <= div + 1'b1;
        end
    end

    always_comb begin
        case (count_clock_select)
            3'h0: exp_sel = tmr_pkg::EXP_SEL0;
            3'h1: exp_sel = tmr_pkg::EXP_SEL1;
            3'h2: exp_sel = tmr_pkg::EXP_SEL2;
            3'h3: exp_sel = tmr_pkg::EXP_SEL3;
            3'h4: exp_sel = tmr_pkg::EXP_SEL4;
            3'h5: exp_sel = tmr_pkg::EXP_SEL5;
            3'h6: exp_sel = EXP_SLOW;
            default: exp_sel = tmr_pkg::EXP_SEL7;
        endcase
        mask = tmr_pkg::PRESCALE_W'((16'h0001 << exp_sel) - 16'h0001);
    end

    assign count_tick = clk_en && ((div & mask) == '0);
endmodule

// >>> rtl/interval_pwm_timer.sv
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// (R01) Interval: period match raises interrupt, clears counter
// (R02) Interval mode never matches the duty register
// (R03) Output enable bit gives 50% square wave
// (R04) Interrupt spacing is period value plus one
// (R05) Counting starts within one count clock
// (R06) Interval match clears, toggles output, interrupts
// (R07) Stop returns interrupt and output to default
// (R08) Software never writes period while PWM runs
// (R09) PWM period match: clear, interrupt, active, duty next
// (R10) PWM duty match: inactive, period next, no clear
// (R11) PWM period N+1, active width M+1
// (R12) Duty write latched, committed at old match
// (R13) Duty match within three clocks skips commit
// (R14) Software rewrites duty on every PWM restart
// (R15) Software keeps duty below period
// (R16) PWM start masks first count clock, inactive
// (R17) PWM stop forces inactive output, default interrupt
// (R18) Run bit low holds counter at zero
// (R19) Level bit picks default output level
// (R20) Mode field changes only while stopped
module interval_pwm_timer #(
    parameter logic [3:0] SLOW_CLOCK_EXP = tmr_pkg::EXP_SEL6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [tmr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [tmr_pkg::BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [tmr_pkg::BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic compare_match_irq,
    output logic timer_output_pin
);
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    logic rst_meta;
    logic rst_sync_n;
    bus_state_t bus_state;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    tmr_pkg::timer_mode_reg_t timer_mode_reg;
    logic [tmr_pkg::DATA_W-1:0] period_compare;
    logic [tmr_pkg::DATA_W-1:0] duty_compare;
    logic [tmr_pkg::DATA_W-1:0] duty_active;
    logic [tmr_pkg::DATA_W-1:0] count;
    logic [tmr_pkg::DATA_W-1:0] next_count;
    logic [tmr_pkg::DATA_W-1:0] target;
    logic [1:0] duty_age;
    logic duty_pending;
    logic duty_selected;
    logic out_phase;
    logic first_masked;
    logic count_tick;
    logic running;
    logic pwm_mode;
    logic advance;
    logic hit;
    logic period_hit;
    logic duty_hit;
    logic commit_duty;
    logic duty_write;
    tmr_pkg::timer_status_t status;

    // Reset released through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // One wait state so read data come from a flop
    assign bus_req = avs_read || avs_write;
    // A frozen bus keeps waiting so no transfer completes unseen
    assign avs_waitrequest = bus_req && (bus_state != BUS_ACK || !clk_en);
    assign bus_take = bus_req && (bus_state == BUS_ACK) && clk_en;
    assign wr_take = bus_take && avs_write && avs_byteenable[0];

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_state <= BUS_IDLE;
        end else if (clk_en) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state <= BUS_ACK;
                    end
                end
                BUS_ACK: bus_state <= BUS_IDLE;
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

    assign status = '{duty_pending: duty_pending, duty_selected: duty_selected,
                      out_phase: out_phase, pin_level: timer_output_pin, count: count};

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= '0;
        end else if (clk_en && avs_read && bus_state == BUS_IDLE) begin
            case (avs_address)
                tmr_pkg::MODE_ADDR: avs_readdata <= tmr_pkg::BUS_W'(timer_mode_reg);
                tmr_pkg::PERIOD_ADDR: avs_readdata <= tmr_pkg::BUS_W'(period_compare);
                tmr_pkg::DUTY_ADDR: avs_readdata <= tmr_pkg::BUS_W'(duty_compare);
                tmr_pkg::STATUS_ADDR: avs_readdata <= tmr_pkg::BUS_W'(status);
                default: avs_readdata <= '0;
            endcase
        end
    end

    // Only the run bit moves while running; other fields refresh only
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_mode_reg <= tmr_pkg::MODE_RESET;
        end else if (wr_take && avs_address == tmr_pkg::MODE_ADDR) begin
            if (timer_mode_reg.count_run_enable) begin
                timer_mode_reg.count_run_enable <= avs_writedata[7]; // see (R20)
            end else begin
                timer_mode_reg <= tmr_pkg::timer_mode_reg_t'(avs_writedata[7:0]);
            end
        end
    end

    // No hardware guard here: keeping it still in PWM is software's job
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            period_compare <= tmr_pkg::PERIOD_RESET;
        end else if (wr_take && avs_address == tmr_pkg::PERIOD_ADDR) begin
            period_compare <= avs_writedata[7:0]; // see (R08)
        end
    end

    assign duty_write = wr_take && avs_address == tmr_pkg::DUTY_ADDR;

    // Bus side holding latch for the duty value
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            duty_compare <= tmr_pkg::DUTY_RESET;
        end else if (duty_write) begin
            duty_compare <= avs_writedata[7:0]; // see (R12)
        end
    end

    count_clock_prescaler #(
        .EXP_SLOW(SLOW_CLOCK_EXP)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .clk_en(clk_en),
        .count_clock_select(timer_mode_reg.count_clock_select),
        .count_tick(count_tick) // see (R05)
    );

    assign running = timer_mode_reg.count_run_enable;
    assign pwm_mode = timer_mode_reg.op_mode == tmr_pkg::MODE_PWM;
    assign advance = running && count_tick && !(pwm_mode && first_masked); // see (R16)

    // Interval mode compares only against the period
    assign target = (pwm_mode && duty_selected) ? duty_active : period_compare; // see (R02)
    assign hit = count == target;
    assign period_hit = advance && hit && !(pwm_mode && duty_selected);
    assign duty_hit = advance && hit && pwm_mode && duty_selected;
    assign commit_duty = duty_hit && duty_pending && duty_age == tmr_pkg::DUTY_SETTLE; // see (R13)

    always_comb begin
        if (period_hit) begin
            next_count = tmr_pkg::COUNT_ZERO; // see (R01) (R04) (R11)
        end else begin
            next_count = count + tmr_pkg::COUNT_ONE; // see (R10)
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count <= tmr_pkg::COUNT_ZERO;
        end else if (clk_en) begin
            if (!running) begin
                count <= tmr_pkg::COUNT_ZERO; // see (R18)
            end else if (advance) begin
                count <= next_count; // see (R06)
            end
        end
    end

    // First tick of a PWM run is swallowed
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            first_masked <= 1'b1;
        end else if (clk_en) begin
            if (!running) begin
                first_masked <= 1'b1;
            end else if (count_tick) begin
                first_masked <= 1'b0; // see (R16)
            end
        end
    end

    // Which compare register is live in PWM
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            duty_selected <= 1'b0;
        end else if (clk_en) begin
            if (!running) begin
                duty_selected <= 1'b0;
            end else if (period_hit && pwm_mode) begin
                duty_selected <= 1'b1; // see (R09)
            end else if (duty_hit) begin
                duty_selected <= 1'b0; // see (R10)
            end
        end
    end

    // Age of an uncommitted write, in count clocks, saturating
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            duty_pending <= 1'b0;
            duty_age <= 2'h0;
        end else if (clk_en) begin
            if (!running) begin
                duty_pending <= 1'b0;
                duty_age <= 2'h0;
            end else if (duty_write) begin
                duty_pending <= 1'b1; // see (R12)
                duty_age <= 2'h0;
            end else begin
                if (commit_duty) begin
                    duty_pending <= 1'b0;
                end
                if (count_tick && duty_age != tmr_pkg::DUTY_SETTLE) begin
                    duty_age <= duty_age + 2'h1;
                end
            end
        end
    end

    // Stopped timer tracks the latch; software rewrites before restart
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            duty_active <= tmr_pkg::DUTY_RESET;
        end else if (clk_en) begin
            if (!running) begin
                duty_active <= duty_compare; // see (R14)
            end else if (commit_duty) begin
                duty_active <= duty_compare; // see (R12)
            end
        end
    end

    // Phase 1 means away from the default level
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_phase <= 1'b0;
        end else if (clk_en) begin
            if (!running) begin
                out_phase <= 1'b0; // see (R07) (R17)
            end else if (pwm_mode) begin
                if (period_hit) begin
                    out_phase <= 1'b1; // see (R09)
                end else if (duty_hit) begin
                    out_phase <= 1'b0; // see (R10)
                end
            end else if (period_hit) begin
                out_phase <= !out_phase; // see (R03) (R06)
            end
        end
    end

    // Pin flop; a disabled output sits at the default level
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_output_pin <= 1'b0;
        end else if (clk_en) begin
            timer_output_pin <= timer_mode_reg.idle_level_select ^
                (out_phase && timer_mode_reg.pin_drive_enable); // see (R19) (R03)
        end
    end

    // One pulse per period match, one clk_en cycle long
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            compare_match_irq <= 1'b0;
        end else if (clk_en) begin
            compare_match_irq <= period_hit && running; // see (R01) (R07) (R17)
        end
    end
endmodule

// >>> dv/interval_pwm_timer_sva.sv
`timescale 1ns/10ps
module interval_pwm_timer_sva #(
    parameter logic [3:0] SLOW_CLOCK_EXP = tmr_pkg::EXP_SEL6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [tmr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [tmr_pkg::BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [tmr_pkg::BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic compare_match_irq,
    input wire logic timer_output_pin
);
    tmr_pkg::timer_mode_reg_t mode_sh;
    logic [7:0] per_sh;
    logic [9:0] gap;
    logic gvalid;
    logic wr_ok;
    logic pwm;
    logic run;
    logic idle;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign pwm = mode_sh.op_mode == tmr_pkg::MODE_PWM;
    assign run = mode_sh.count_run_enable;
    assign idle = mode_sh.idle_level_select;
    // Shadow of the programmed setup; running locks all but the run bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_sh <= '0;
        end else if (wr_ok && avs_address == tmr_pkg::MODE_ADDR) begin
            if (run) begin
                mode_sh.count_run_enable <= avs_writedata[7];
            end else begin
                mode_sh <= avs_writedata[7:0];
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_sh <= '0;
        end else if (wr_ok && avs_address == tmr_pkg::PERIOD_ADDR) begin
            per_sh <= avs_writedata[7:0];
        end
    end
    // Spacing only trusted after one full period with no reprogramming
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gvalid <= 1'b0;
            gap <= '0;
        end else if (wr_ok || !run) begin
            gvalid <= 1'b0;
        end else if (compare_match_irq) begin
            gvalid <= 1'b1;
            gap <= 10'h001;
        end else begin
            gap <= gap + 10'h001;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_stop;
        wr_ok && run && avs_address == tmr_pkg::MODE_ADDR && !avs_writedata[7];
    endsequence
    sequence s_quiet;
        !compare_match_irq ##1 (!compare_match_irq && timer_output_pin == idle);
    endsequence
    property p_no_wait;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    property p_one_wait;
        ((avs_read || avs_write) && avs_waitrequest && clk_en) ##1 clk_en |-> !avs_waitrequest;
    endproperty
    property p_irq_pulse;
        compare_match_irq && clk_en && per_sh != 8'h00 |=> !compare_match_irq;
    endproperty
    property p_stop;
        s_stop |=> ##1 s_quiet;
    endproperty
    property p_gap;
        compare_match_irq && gvalid && !pwm && mode_sh.count_clock_select == 3'h0
            |-> gap == {2'h0, per_sh} + 10'h001;
    endproperty
    property p_toggle;
        compare_match_irq && run && !pwm && mode_sh.pin_drive_enable && !wr_ok ##1 !wr_ok
            |-> $changed(timer_output_pin);
    endproperty
    property p_pwm_start;
        $rose(run) && pwm && per_sh != 8'h00 |-> (timer_output_pin == idle) [*2];
    endproperty
    property p_pwm_active;
        compare_match_irq && clk_en && run && pwm && mode_sh.pin_drive_enable && !wr_ok
            |=> timer_output_pin != idle;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("waitrequest without request");
    a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    a_stop: assert property (p_stop) else $error("stop left irq or pin active");
    a_gap: assert property (p_gap) else $error("irq spacing wrong");
    a_toggle: assert property (p_toggle) else $error("pin did not toggle");
    a_pwm_start: assert property (p_pwm_start) else $error("pwm start not inactive");
    a_pwm_active: assert property (p_pwm_active) else $error("pwm not active");
endmodule
bind interval_pwm_timer interval_pwm_timer_sva #(.SLOW_CLOCK_EXP(SLOW_CLOCK_EXP)) u_sva (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .compare_match_irq(compare_match_irq),
    .timer_output_pin(timer_output_pin)
);

// >>> dv/interval_pwm_timer_bench.sv
`timescale 1ns/10ps
module interval_pwm_timer_bench;
    logic sys_clk;
    logic rst_n;
    logic clk_en;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic compare_match_irq;
    logic timer_output_pin;
    logic [31:0] rd;
    int miscompares;
    int num_checks;
    int g;
    int h;
    int h0;
    interval_pwm_timer #(.SLOW_CLOCK_EXP(4'h2)) u_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .compare_match_irq(compare_match_irq),
        .timer_output_pin(timer_output_pin)
    );
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tmo;
        miscompares++;
        $display("timeout at %0t", $time);
        stop_test();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) tmo();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Cycles from one irq to the next, and how many of them had the pin high
    task automatic meas(output int gp, output int hp);
        int n;
        for (n = 0; n < 13000 && compare_match_irq !== 1'b1; n++) @(negedge sys_clk);
        if (n == 13000) tmo();
        gp = 0;
        hp = 0;
        do begin
            @(negedge sys_clk);
            gp++;
            if (timer_output_pin === 1'b1) hp++;
        end while (compare_match_irq !== 1'b1 && gp < 13000);
        if (gp == 13000) tmo();
    endtask
    task automatic t_regs;
        logic [3:0] addr [3];
        addr = '{tmr_pkg::MODE_ADDR, tmr_pkg::PERIOD_ADDR, tmr_pkg::DUTY_ADDR};
        bus(1'b0, tmr_pkg::STATUS_ADDR, 8'h00);
        chk(rd, 32'h0);
        foreach (addr[i]) begin
            bus(1'b0, addr[i], 8'h00);
            chk(rd, 32'h0);
            bus(1'b1, addr[i], 8'h5A);
            bus(1'b0, addr[i], 8'h00);
            chk(rd, 32'h5A);
        end
        avs_byteenable <= 4'h0;
        bus(1'b1, tmr_pkg::PERIOD_ADDR, 8'hFF);
        avs_byteenable <= 4'hF;
        bus(1'b0, tmr_pkg::PERIOD_ADDR, 8'h00);
        chk(rd, 32'h5A);
        bus(1'b1, 4'h2, 8'hFF);
        bus(1'b0, 4'h2, 8'h00);
        chk(rd, 32'h0);
        repeat (3) @(negedge sys_clk);
        chk({31'h0, timer_output_pin}, 32'h1);
        bus(1'b1, tmr_pkg::MODE_ADDR, 8'h00);
        $display("registers test done");
    endtask
    task automatic t_interval;
        logic [2:0] sel [8];
        int dv [8];
        sel = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        // Select 6 divides by 4 here because the bench shortens its exponent to 2
        dv = '{1, 4, 16, 64, 4096, 64, 4, 1};
        bus(1'b1, tmr_pkg::PERIOD_ADDR, 8'h02);
        bus(1'b1, tmr_pkg::DUTY_ADDR, 8'h00);
        foreach (sel[i]) begin
            bus(1'b1, tmr_pkg::MODE_ADDR, {1'b1, sel[i], 4'h1});
            meas(g, h0);
            meas(g, h0);
            meas(g, h);
            chk(g, 3 * dv[i]);
            chk(h + h0, 3 * dv[i]);
            bus(1'b1, tmr_pkg::MODE_ADDR, 8'h00);
            repeat (3) @(negedge sys_clk);
            chk({30'h0, compare_match_irq, timer_output_pin}, 32'h0);
            bus(1'b0, tmr_pkg::STATUS_ADDR, 8'h00);
            chk({24'h0, rd[7:0]}, 32'h0);
        end
        $display("interval test done");
    endtask
    task automatic t_pwm;
        bus(1'b1, tmr_pkg::PERIOD_ADDR, 8'h07);
        bus(1'b1, tmr_pkg::DUTY_ADDR, 8'h02);
        bus(1'b1, tmr_pkg::MODE_ADDR, 8'h89);
        @(negedge sys_clk);
        chk({31'h0, timer_output_pin}, 32'h0);
        bus(1'b1, tmr_pkg::MODE_ADDR, 8'h81);
        bus(1'b0, tmr_pkg::MODE_ADDR, 8'h00);
        chk(rd, 32'h89);
        meas(g, h);
        meas(g, h);
        chk(g, 8);
        chk(h, 3);
        bus(1'b1, tmr_pkg::DUTY_ADDR, 8'h04);
        repeat (3) meas(g, h);
        chk(h, 5);
        // Lands two ticks before the old duty match, too young to commit there
        bus(1'b1, tmr_pkg::DUTY_ADDR, 8'h01);
        meas(g, h);
        chk(h, 5);
        meas(g, h);
        chk(h, 2);
        // Frozen just after the period match: pin must hold its active level
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            chk({30'h0, compare_match_irq, timer_output_pin}, 32'h1);
        end
        @(posedge sys_clk);
        clk_en <= 1'b1;
        meas(g, h);
        chk(g, 8);
        bus(1'b1, tmr_pkg::MODE_ADDR, 8'h00);
        repeat (3) @(negedge sys_clk);
        chk({30'h0, compare_match_irq, timer_output_pin}, 32'h0);
        $display("pwm test done");
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        miscompares = 0;
        num_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_interval();
        t_pwm();
        stop_test();
    end
endmodule
